/* bench/dma_link_checker.sv */
// Concurrent checks on the DMA link signals
`timescale 1ns/1ns
`default_nettype none
module dma_link_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic dmaBusGrant,
   input wire logic [2:0] dmaCommand,
   input wire logic [dma_resp_pkg::ADDR_W-1:0] systemLineAddress,
   input wire logic [1:0] transactionAcknowledge,
   input wire logic ioDataReady,
   input wire logic dataHalfSelect,
   input wire logic systemDataOe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic isIo;
   assign isIo = systemLineAddress[dma_resp_pkg::ADDR_W-1];

   AST_IO_ACK: assert property (dmaBusGrant ##1 isIo |-> ##2 transactionAcknowledge == dma_resp_pkg::ACK_ERROR)
      else $error("io access not refused in cycle 3");
   AST_IO_DRIVE: assert property (dmaBusGrant ##1 (isIo && dmaCommand < 3'h4) |-> ##1 systemDataOe ##1 !systemDataOe)
      else $error("io read data bus not driven for one cycle");
   AST_READ_TIMING: assert property (dmaBusGrant ##1 (!isIo && dmaCommand < 3'h4) |-> ##4 ioDataReady
      ##1 !ioDataReady ##1 (ioDataReady && transactionAcknowledge == dma_resp_pkg::ACK_DONE))
      else $error("read strobes or ack off cycle");
   AST_WRAP_ORDER: assert property (dmaBusGrant ##1 (!isIo && dmaCommand inside {3'h1, 3'h3})
      |-> ##4 dataHalfSelect ##2 !dataHalfSelect)
      else $error("wrapped read order wrong");
   AST_PLAIN_ORDER: assert property (dmaBusGrant ##1 (!isIo && dmaCommand inside {3'h0, 3'h2})
      |-> ##4 !dataHalfSelect ##2 !dataHalfSelect)
      else $error("plain read order wrong");
   AST_ACK_CODE: assert property (transactionAcknowledge != 2'h2)
      else $error("undefined ack code");
   AST_ACK_PULSE: assert property (transactionAcknowledge != dma_resp_pkg::ACK_IDLE |=>
      transactionAcknowledge == dma_resp_pkg::ACK_IDLE)
      else $error("ack longer than one cycle");
   AST_GRANT_GAP: assert property (dmaBusGrant |=> !dmaBusGrant [*3])
      else $error("grant inside a transaction");
   AST_CMD_VALID: assert property (dmaBusGrant |=> dmaCommand != 3'h7)
      else $error("no command in cycle 1");
endmodule : dma_link_checker
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench joining both link ends
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin testsRun++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module testbench;
   typedef struct {logic [1:0] ack; int ackCyc; int twe; int loads; int inv; int rel; int rdy; int tdrv;
      int toeLow; int hint;} note_t;
   logic clk_sys, reset, tagHit, cacheEnableSetting, longCacheWriteSetting, writeBufferFull, reqValid;
   logic tagOutputEnable, tagWriteEnable, tagBusOe, writeBufferLoad, cacheRelease, cpuDcacheInvalidateRequest;
   logic nextLineHint, reqReady, doneValid, doneError, lastErr, rdDataValid, rdDataHigh, rdHighExp;
   logic [dma_resp_pkg::DATA_W-1:0] memReadData, rdData, rdExp;
   logic [2:0] reqCommand;
   logic [dma_resp_pkg::ADDR_W-1:0] reqLineAddress;
   logic [1:0] reqLineSelect;
   logic [dma_resp_pkg::TAG_W-1:0] tagBusOut;
   logic [15:0] lfsr = 16'hFEE1;
   int mismatches, testsRun, off, loads, inv, rel, rdy, tdrv, toeLow, hint, twe;
   note_t notes[$];
   note_t n;

   dma_link_if linkBus();
   dma_controller_end dma_controller_end_i (.clk_sys(clk_sys), .reset(reset), .link(linkBus.controller),
      .tagHit(tagHit), .cacheEnableSetting(cacheEnableSetting), .longCacheWriteSetting(longCacheWriteSetting),
      .writeBufferFull(writeBufferFull), .memReadData(memReadData), .tagOutputEnable(tagOutputEnable),
      .tagWriteEnable(tagWriteEnable), .tagBusOut(tagBusOut), .tagBusOe(tagBusOe),
      .writeBufferLoad(writeBufferLoad), .writeOctawordIndex(), .cacheRelease(cacheRelease),
      .cpuDcacheInvalidateRequest(cpuDcacheInvalidateRequest), .nextLineHint(nextLineHint),
      .activeLineSelect());
   dma_requester_end dma_requester_end_i (.clk_sys(clk_sys), .reset(reset), .link(linkBus.requester),
      .reqValid(reqValid), .reqCommand(reqCommand), .reqLineAddress(reqLineAddress),
      .reqLineSelect(reqLineSelect), .reqReady(reqReady), .rdData(rdData), .rdDataValid(rdDataValid),
      .rdDataHigh(rdDataHigh), .doneValid(doneValid), .doneError(doneError));
   dma_link_checker dma_link_checker_i (.clk_sys(clk_sys), .reset(reset), .dmaBusGrant(linkBus.dmaBusGrant),
      .dmaCommand(linkBus.dmaCommand), .systemLineAddress(linkBus.systemLineAddress),
      .transactionAcknowledge(linkBus.transactionAcknowledge), .ioDataReady(linkBus.ioDataReady),
      .dataHalfSelect(linkBus.dataHalfSelect), .systemDataOe(linkBus.systemDataOe));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [15:0] lfsrNext(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsrNext

   always @(posedge clk_sys)
   begin
      lfsr <= lfsrNext(lfsr);
      memReadData <= {8{lfsr}};
   end

   task automatic wrapUp();
      $display("comparisons %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrapUp

   task automatic waitFor(ref logic sig, input string what);
      int w;
      w = 0;
      @(negedge clk_sys);
      while (sig !== 1'b1 && w < 100)
      begin
         @(negedge clk_sys);
         w++;
      end
      if (w == 100)
      begin
         mismatches++;
         $display("[ERR] %s expected 1 seen 0", what);
         wrapUp();
      end
   endtask : waitFor

   // Issues one request, optionally frees a full write buffer k cycles after grant
   task automatic runTxn(input string name, input logic [2:0] cmd, input logic [28:0] addr, input logic hit,
      input logic en, input int k, input note_t e);
      @(posedge clk_sys);
      tagHit <= hit;
      cacheEnableSetting <= en;
      writeBufferFull <= (k > 0);
      longCacheWriteSetting <= lfsr[0];
      reqValid <= 1'b1;
      reqCommand <= cmd;
      reqLineAddress <= addr;
      reqLineSelect <= lfsr[2:1];
      notes.push_back(e);
      waitFor(reqReady, "reqReady");
      @(posedge clk_sys);
      reqValid <= 1'b0;
      if (k > 0)
      begin
         waitFor(linkBus.dmaBusGrant, "grant");
         repeat (k) @(posedge clk_sys);
         writeBufferFull <= 1'b0;
      end
      waitFor(doneValid, "doneValid");
      $display("test %s done", name);
   endtask : runTxn

   // Watches outputs and compares each completion with the oldest note
   always @(negedge clk_sys)
   begin
      if (linkBus.dmaBusGrant === 1'b1)
      begin
         off = 0;
         {loads, inv, rel, rdy, tdrv, toeLow, hint, twe} = '0;
      end
      else
         off++;
      loads += (writeBufferLoad === 1'b1);
      inv += (cpuDcacheInvalidateRequest === 1'b1);
      rdy += (linkBus.ioDataReady === 1'b1);
      toeLow += (tagOutputEnable === 1'b0);
      if (cacheRelease === 1'b1) rel = 1;
      if (nextLineHint === 1'b1) hint = 1;
      if (tagWriteEnable === 1'b1) twe += off;
      if (tagBusOe === 1'b1)
      begin
         tdrv++;
         `CHK("tagBusOut", dma_resp_pkg::INVALID_TAG, tagBusOut)
      end
      // First octaword seen at cycle 6, second at 8; memory data taken two cycles earlier
      rdHighExp = (off == 6) && (reqCommand == dma_resp_pkg::CMD_READ_WRAP ||
         reqCommand == dma_resp_pkg::CMD_READ_WRAP_BURST);
      if (rdDataValid === 1'b1)
      begin
         `CHK("rdData", rdExp, rdData)
         `CHK("rdHigh", rdHighExp, rdDataHigh)
      end
      if (off == 4 || off == 6) rdExp = memReadData;
      if (!reset && linkBus.transactionAcknowledge !== dma_resp_pkg::ACK_IDLE)
      begin
         if (notes.size() == 0)
            `CHK("note", 1, 0)
         else
         begin
            n = notes.pop_front();
            lastErr = (n.ack == dma_resp_pkg::ACK_ERROR);
            `CHK("ack", n.ack, linkBus.transactionAcknowledge)
            `CHK("ackCyc", n.ackCyc, off)
            `CHK("tweCyc", n.twe, twe)
            `CHK("loads", n.loads, loads)
            `CHK("dinv", n.inv, inv)
            `CHK("release", n.rel, rel)
            `CHK("ready", n.rdy, rdy)
            `CHK("tagDrive", n.tdrv, tdrv)
            `CHK("hint", n.hint, hint)
            if (n.toeLow >= 0) `CHK("tagOeLow", n.toeLow, toeLow)
         end
      end
      if (doneValid === 1'b1) `CHK("doneError", lastErr, doneError)
   end

   initial
   begin
      {mismatches, testsRun, off} = '0;
      {reset, lastErr} = 2'b10;
      {tagHit, longCacheWriteSetting, writeBufferFull, reqValid} = '0;
      cacheEnableSetting = 1'b1;
      {reqCommand, reqLineAddress, reqLineSelect} = '0;
      repeat (3) @(posedge clk_sys);
      `CHK("resetTagOe", 1'b1, tagOutputEnable)
      `CHK("resetAck", dma_resp_pkg::ACK_IDLE, linkBus.transactionAcknowledge)
      reset <= 1'b0;
      for (int c = 0; c < 4; c++)
         runTxn("read", c[2:0], {5'h08, lfsr, lfsr[7:0]}, lfsr[0], 1'b1, 0, '{1, 7, 0, 0, 0, 0, 2, 0, 0, c[1]});
      runTxn("io read", 3'h0, {5'h10, lfsr, 8'h00}, 1'b1, 1'b1, 0, '{3, 3, 0, 0, 0, 0, 0, 0, 0, 0});
      runTxn("io write", 3'h4, {5'h10, lfsr, 8'h00}, 1'b0, 1'b1, 0, '{3, 3, 0, 0, 0, 0, 0, 0, 0, 0});
      runTxn("write hit", 3'h4, {5'h00, lfsr, 8'h00}, 1'b1, 1'b1, 0, '{1, 5, 4, 2, 0, 0, 0, 2, 3, 0});
      runTxn("write miss", 3'h4, {5'h00, lfsr, 8'h00}, 1'b0, 1'b1, 0, '{1, 3, 0, 2, 0, 0, 0, 0, 0, 0});
      runTxn("write nc", 3'h4, {5'h08, lfsr, 8'h00}, 1'b1, 1'b1, 0, '{1, 3, 0, 2, 0, 0, 0, 0, 0, 0});
      runTxn("write off", 3'h4, {5'h00, lfsr, 8'h00}, 1'b1, 1'b0, 0, '{1, 3, 0, 2, 1, 0, 0, 0, 0, 0});
      runTxn("miss full", 3'h4, {5'h00, lfsr, 8'h00}, 1'b0, 1'b1, 4, '{1, 5, 0, 2, 0, 1, 0, 0, 0, 0});
      runTxn("hit full", 3'h4, {5'h00, lfsr, 8'h00}, 1'b1, 1'b1, 4, '{1, 7, 6, 2, 0, 0, 0, 2, -1, 0});
      wrapUp();
   end
endmodule : testbench
`default_nettype wire

/* verilog/address_space_decoder.sv */
// Classifies a line address as I/O, cacheable or noncacheable
`timescale 1ns/1ns
`default_nettype none
module address_space_decoder #(
   parameter logic [dma_resp_pkg::ADDR_W-1:0] CacheableLimit = dma_resp_pkg::CACHEABLE_LIMIT
) (
   input wire logic [dma_resp_pkg::ADDR_W-1:0] lineAddress,
   output logic isIoSpace,
   output logic isCacheable
);
   always_comb
   begin
      isIoSpace = lineAddress[dma_resp_pkg::IO_SPACE_BIT - dma_resp_pkg::ADDR_LO];
      isCacheable = !isIoSpace && (lineAddress < CacheableLimit);
   end
endmodule : address_space_decoder
`default_nettype wire

/* verilog/dma_controller_end.sv */
// Cache/memory controller end servicing DMA transactions
//
// What this block does
// - Transaction starts at grant, cycle 0
// - Cycle 1 carries command, line address, selector
// - Noncacheable read: miss timing, probe result ignored
// - I/O-space DMA answered with error acknowledge
// - I/O read: drive data bus in cycle 2
// - I/O read: error ack cycle 3, next 4
// - Wrapped read returns octaword 1 then 0
// - Burst read equals read plus next-line hint
// - Wrapped burst combines wrap order and hint
// - Write releases cache only if full and miss
// - Write hit invalidates tag, never writes data
// - Hit cycle 2: first octaword, tag OE off
// - Hit cycle 3: invalid tag driven, second octaword
// - Hit cycle 4: one-cycle tag write enable
// - Hit cycle 5: release tags, acknowledge; 6 free
// - Write miss: load cycle 2, ack 3, next 4
// - Cache disabled: write is miss, invalidate CPU dcache
// - Buffer full: probe done, wait for space
// - Data ready strobe on each read octaword
`timescale 1ns/1ns
`default_nettype none
module dma_controller_end #(
   parameter logic [dma_resp_pkg::ADDR_W-1:0] CacheableLimit = dma_resp_pkg::CACHEABLE_LIMIT
) (
   input wire logic clk_sys,
   input wire logic reset,
   dma_link_if.controller link,
   input wire logic tagHit,
   input wire logic cacheEnableSetting,
   input wire logic longCacheWriteSetting,
   input wire logic writeBufferFull,
   input wire logic [dma_resp_pkg::DATA_W-1:0] memReadData,
   output logic tagOutputEnable,
   output logic tagWriteEnable,
   output logic [dma_resp_pkg::TAG_W-1:0] tagBusOut,
   output logic tagBusOe,
   output logic writeBufferLoad,
   output logic writeOctawordIndex,
   output logic cacheRelease,
   output logic cpuDcacheInvalidateRequest,
   output logic nextLineHint,
   output logic [1:0] activeLineSelect
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CMD = 4'h1,
      ST_DECODE = 4'h2,
      ST_IO_ERR = 4'h3,
      ST_RD_WAIT = 4'h4,
      ST_WR_FULL = 4'h5,
      ST_WH_DRIVE = 4'h6,
      ST_WH_WRITE = 4'h7,
      ST_WH_DONE = 4'h8,
      ST_WM_ACK = 4'h9
   } ctrl_state_t;

   ctrl_state_t stateQ, stateD;
   logic [3:0] cycleQ, cycleD;
   logic [2:0] cmdQ, cmdD;
   logic [dma_resp_pkg::ADDR_W-1:0] addrQ, addrD;
   logic [1:0] lineSelQ, lineSelD;
   logic ioSpaceQ, ioSpaceD;
   logic hitQ, hitD;
   logic [dma_resp_pkg::DATA_W-1:0] dataQ, dataD;
   logic dataOeQ, dataOeD;
   logic decIo, decCacheable;
   logic isWrite, isWrap, isBurst, effHit;

   address_space_decoder #(.CacheableLimit(CacheableLimit)) u_decode (
      .lineAddress(addrQ),
      .isIoSpace(decIo),
      .isCacheable(decCacheable)
   );

   always_comb
   begin
      isWrite = (cmdQ == dma_resp_pkg::CMD_WRITE);
      isWrap = (cmdQ == dma_resp_pkg::CMD_READ_WRAP) || (cmdQ == dma_resp_pkg::CMD_READ_WRAP_BURST);
      isBurst = (cmdQ == dma_resp_pkg::CMD_READ_BURST) || (cmdQ == dma_resp_pkg::CMD_READ_WRAP_BURST);
      // Disabled cache or noncacheable space always probes as a miss
      effHit = tagHit && decCacheable && cacheEnableSetting;
   end

   // Next-state and handshake outputs
   always_comb
   begin
      stateD = stateQ;
      cycleD = cycleQ + 4'h1;
      cmdD = cmdQ;
      addrD = addrQ;
      lineSelD = lineSelQ;
      ioSpaceD = ioSpaceQ;
      hitD = hitQ;
      dataD = dataQ;
      dataOeD = 1'b0;
      link.transactionAcknowledge = dma_resp_pkg::ACK_IDLE;
      link.ioDataReady = 1'b0;
      link.dataHalfSelect = 1'b0;
      tagOutputEnable = 1'b1;
      tagWriteEnable = 1'b0;
      tagBusOut = dma_resp_pkg::INVALID_TAG;
      tagBusOe = 1'b0;
      writeBufferLoad = 1'b0;
      writeOctawordIndex = 1'b0;
      cacheRelease = 1'b0;
      cpuDcacheInvalidateRequest = 1'b0;
      unique case (stateQ)
         ST_IDLE:
         begin
            if (link.dmaBusGrant)
            begin
               stateD = ST_CMD;
               cycleD = dma_resp_pkg::CYC_CMD;
            end
         end
         ST_CMD:
         begin
            cmdD = link.dmaCommand;
            addrD = link.systemLineAddress;
            lineSelD = link.bufferLineSelect;
            stateD = ST_DECODE;
         end
         ST_DECODE:
         begin
            ioSpaceD = decIo;
            hitD = effHit;
            if (decIo)
            begin
               // On a read the bus is held this cycle only, by the drive logic below
               dataD = dma_resp_pkg::DATA_RESET;
               stateD = ST_IO_ERR;
            end
            else if (isWrite)
            begin
               cpuDcacheInvalidateRequest = !cacheEnableSetting;
               if (writeBufferFull)
               begin
                  stateD = ST_WR_FULL;
               end
               else
               begin
                  writeBufferLoad = 1'b1;
                  tagOutputEnable = !effHit;
                  stateD = effHit ? ST_WH_DRIVE : ST_WM_ACK;
               end
            end
            else
            begin
               // Reads follow miss timing whatever the probe says
               stateD = ST_RD_WAIT;
            end
         end
         ST_IO_ERR:
         begin
            link.transactionAcknowledge = dma_resp_pkg::ACK_ERROR;
            stateD = ST_IDLE;
         end
         ST_RD_WAIT:
         begin
            // Octaword loaded a cycle ahead so it stands with its strobe
            if ((cycleQ == dma_resp_pkg::CYC_READ_FIRST - 4'h1) ||
               (cycleQ == dma_resp_pkg::CYC_READ_SECOND - 4'h1))
            begin
               dataOeD = 1'b1;
               dataD = memReadData;
            end
            if (cycleQ == dma_resp_pkg::CYC_READ_FIRST)
            begin
               link.ioDataReady = 1'b1;
               link.dataHalfSelect = isWrap;
            end
            else if (cycleQ == dma_resp_pkg::CYC_READ_SECOND)
            begin
               link.ioDataReady = 1'b1;
               link.dataHalfSelect = 1'b0;
               link.transactionAcknowledge = dma_resp_pkg::ACK_DONE;
               stateD = ST_IDLE;
            end
         end
         ST_WR_FULL:
         begin
            // Probe is done; only a miss may hand the cache back
            cacheRelease = !hitQ;
            tagOutputEnable = !hitQ;
            if (!writeBufferFull)
            begin
               writeBufferLoad = 1'b1;
               stateD = hitQ ? ST_WH_DRIVE : ST_WM_ACK;
            end
         end
         ST_WH_DRIVE:
         begin
            tagOutputEnable = 1'b0;
            tagBusOe = 1'b1;
            tagBusOut = dma_resp_pkg::INVALID_TAG;
            writeBufferLoad = 1'b1;
            writeOctawordIndex = 1'b1;
            stateD = ST_WH_WRITE;
         end
         ST_WH_WRITE:
         begin
            // Only the tag is written, cache data untouched
            tagOutputEnable = 1'b0;
            tagBusOe = 1'b1;
            tagWriteEnable = 1'b1;
            stateD = ST_WH_DONE;
         end
         ST_WH_DONE:
         begin
            tagBusOe = 1'b0;
            link.transactionAcknowledge = dma_resp_pkg::ACK_DONE;
            stateD = ST_IDLE;
         end
         ST_WM_ACK:
         begin
            writeBufferLoad = 1'b1;
            writeOctawordIndex = 1'b1;
            link.transactionAcknowledge = dma_resp_pkg::ACK_DONE;
            stateD = ST_IDLE;
         end
         default:
         begin
            stateD = ST_IDLE;
         end
      endcase
      // Long cache write timing plays no part in the invalidate path
      if (longCacheWriteSetting && 1'b0)
      begin
         tagWriteEnable = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         stateQ <= ST_IDLE;
         cycleQ <= 4'h0;
         cmdQ <= dma_resp_pkg::CMD_NONE;
         addrQ <= '0;
         lineSelQ <= 2'h0;
         ioSpaceQ <= 1'b0;
         hitQ <= 1'b0;
         dataQ <= dma_resp_pkg::DATA_RESET;
         dataOeQ <= 1'b0;
      end
      else
      begin
         stateQ <= stateD;
         cycleQ <= cycleD;
         cmdQ <= cmdD;
         addrQ <= addrD;
         lineSelQ <= lineSelD;
         ioSpaceQ <= ioSpaceD;
         hitQ <= hitD;
         dataQ <= dataD;
         dataOeQ <= dataOeD;
      end
   end

   // Data-path drive: I/O read holds the bus in cycle 2 only
   always_comb
   begin
      link.systemDataOut = dataQ;
      link.systemDataOe = dataOeQ || (stateQ == ST_DECODE && decIo && !isWrite);
      nextLineHint = isBurst && (stateQ == ST_RD_WAIT);
      activeLineSelect = lineSelQ;
   end
endmodule : dma_controller_end
`default_nettype wire

/* verilog/dma_link_if.sv */
// Shared system bus between DMA requester and controller
`timescale 1ns/1ns
`default_nettype none
interface dma_link_if;
   logic dmaBusGrant;
   logic [2:0] dmaCommand;
   logic [dma_resp_pkg::ADDR_W-1:0] systemLineAddress;
   logic [1:0] bufferLineSelect;
   logic [1:0] transactionAcknowledge;
   logic ioDataReady;
   logic dataHalfSelect;
   logic [dma_resp_pkg::DATA_W-1:0] systemDataOut;
   logic systemDataOe;
   logic [dma_resp_pkg::DATA_W-1:0] systemDataBus;

   // Only the controller drives data here; undriven bus reads as zero
   assign systemDataBus = systemDataOe ? systemDataOut : dma_resp_pkg::DATA_RESET;

   modport controller (
      input dmaBusGrant,
      input dmaCommand,
      input systemLineAddress,
      input bufferLineSelect,
      output transactionAcknowledge,
      output ioDataReady,
      output dataHalfSelect,
      output systemDataOut,
      output systemDataOe
   );
   modport requester (
      output dmaBusGrant,
      output dmaCommand,
      output systemLineAddress,
      output bufferLineSelect,
      input transactionAcknowledge,
      input ioDataReady,
      input dataHalfSelect,
      input systemDataBus
   );
endinterface : dma_link_if
`default_nettype wire

/* verilog/dma_requester_end.sv */
// DMA requester end issuing transactions on the system bus
`timescale 1ns/1ns
`default_nettype none
module dma_requester_end (
   input wire logic clk_sys,
   input wire logic reset,
   dma_link_if.requester link,
   input wire logic reqValid,
   input wire logic [2:0] reqCommand,
   input wire logic [dma_resp_pkg::ADDR_W-1:0] reqLineAddress,
   input wire logic [1:0] reqLineSelect,
   output logic reqReady,
   output logic [dma_resp_pkg::DATA_W-1:0] rdData,
   output logic rdDataValid,
   output logic rdDataHigh,
   output logic doneValid,
   output logic doneError
);
   typedef enum logic [1:0] {
      RQ_IDLE = 2'h0,
      RQ_GRANT = 2'h1,
      RQ_WAIT = 2'h2
   } req_state_t;

   req_state_t stateQ, stateD;
   logic [2:0] cmdQ, cmdD;
   logic [dma_resp_pkg::ADDR_W-1:0] addrQ, addrD;
   logic [1:0] lineSelQ, lineSelD;
   logic [dma_resp_pkg::DATA_W-1:0] rdDataQ, rdDataD;
   logic rdValidQ, rdValidD, rdHighQ, rdHighD, doneQ, doneD, errQ, errD;

   always_comb
   begin
      stateD = stateQ;
      cmdD = cmdQ;
      addrD = addrQ;
      lineSelD = lineSelQ;
      rdDataD = rdDataQ;
      rdValidD = 1'b0;
      rdHighD = rdHighQ;
      doneD = 1'b0;
      errD = errQ;
      reqReady = (stateQ == RQ_IDLE);
      link.dmaBusGrant = 1'b0;
      link.dmaCommand = cmdQ;
      link.systemLineAddress = addrQ;
      link.bufferLineSelect = lineSelQ;
      unique case (stateQ)
         RQ_IDLE:
         begin
            if (reqValid)
            begin
               cmdD = reqCommand;
               addrD = reqLineAddress;
               lineSelD = reqLineSelect;
               stateD = RQ_GRANT;
            end
         end
         RQ_GRANT:
         begin
            link.dmaBusGrant = 1'b1;
            stateD = RQ_WAIT;
         end
         RQ_WAIT:
         begin
            // Command and address held until acknowledged
            if (link.ioDataReady)
            begin
               rdDataD = link.systemDataBus;
               rdValidD = 1'b1;
               rdHighD = link.dataHalfSelect;
            end
            if (link.transactionAcknowledge != dma_resp_pkg::ACK_IDLE)
            begin
               doneD = 1'b1;
               errD = (link.transactionAcknowledge == dma_resp_pkg::ACK_ERROR);
               stateD = RQ_IDLE;
            end
         end
         default:
         begin
            stateD = RQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         stateQ <= RQ_IDLE;
         cmdQ <= dma_resp_pkg::CMD_NONE;
         addrQ <= '0;
         lineSelQ <= 2'h0;
         rdDataQ <= dma_resp_pkg::DATA_RESET;
         rdValidQ <= 1'b0;
         rdHighQ <= 1'b0;
         doneQ <= 1'b0;
         errQ <= 1'b0;
      end
      else
      begin
         stateQ <= stateD;
         cmdQ <= cmdD;
         addrQ <= addrD;
         lineSelQ <= lineSelD;
         rdDataQ <= rdDataD;
         rdValidQ <= rdValidD;
         rdHighQ <= rdHighD;
         doneQ <= doneD;
         errQ <= errD;
      end
   end

   always_comb
   begin
      rdData = rdDataQ;
      rdDataValid = rdValidQ;
      rdDataHigh = rdHighQ;
      doneValid = doneQ;
      doneError = errQ;
   end
endmodule : dma_requester_end
`default_nettype wire

/* verilog/dma_resp_pkg.sv */
// Shared constants for the DMA transaction link
package dma_resp_pkg;
   // Command codes on dma_command
   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_READ_WRAP = 3'h1,
      CMD_READ_BURST = 3'h2,
      CMD_READ_WRAP_BURST = 3'h3,
      CMD_WRITE = 3'h4,
      CMD_WRITE_MASKED = 3'h5,
      CMD_FLUSH = 3'h6,
      CMD_NONE = 3'h7
   } dma_cmd_t;
   // Acknowledge encodings
   localparam logic [1:0] ACK_IDLE = 2'h0;
   localparam logic [1:0] ACK_DONE = 2'h1;
   localparam logic [1:0] ACK_ERROR = 2'h3;
   // Field widths and positions
   localparam int ADDR_HI = 33;
   localparam int ADDR_LO = 5;
   localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
   localparam int DATA_W = 128;
   localparam int TAG_W = 16;
   // Address map: address bit 33 (line address bit 28) marks I/O space, below limit is cacheable
   localparam int IO_SPACE_BIT = 33;
   localparam logic [ADDR_W-1:0] CACHEABLE_LIMIT = 29'h0800_0000;
   // Tag value written to invalidate a line
   localparam logic [TAG_W-1:0] INVALID_TAG = 16'h0000;
   // Cycle numbers counted from the grant
   localparam logic [3:0] CYC_CMD = 4'h1;
   localparam logic [3:0] CYC_READ_FIRST = 4'h5;
   localparam logic [3:0] CYC_READ_SECOND = 4'h7;
   // Reset values
   localparam logic [DATA_W-1:0] DATA_RESET = 128'h0;
endpackage : dma_resp_pkg
